// file: hdl/acpm_ctrl.sv
`timescale 1ns/10ps
`include "acpm_regs.svh"
`default_nettype none
// Behaviour
// RULE1: word mode loads all twelve data lines, line 0 least significant.
// RULE2: byte mode uses two writes on lines 0-7; line 8 picks high or low byte.
// RULE3: high byte write maps data line 0 to word bit 8.
// RULE4: host sends the low byte first, then the upper four bits.
// RULE5: host keeps top four bits of the high byte at zero.
// RULE6: data is captured at the rising edge of the write strobe.
// RULE7: a write happens only while chip select and write strobe are both low.
// RULE8: two mode bits pick normal, autoshutdown, autostandby or full shutdown.
// RULE9: reset selects normal mode, always powered; code powers down if normal is written as an auto-mode conversion ends.
// RULE10: after reset sampler holds; first convert start rise sets track.
// RULE11: autoshutdown powers all down and holds at conversion end, word kept.
// RULE12: autoshutdown wakes and tracks on the next convert start rise.
// RULE13: host waits 10 ms after autoshutdown wake before converting.
// RULE14: host should idle convert start low in autoshutdown.
// RULE15: autostandby keeps reference, powers rest down, wakes on convert start rise.
// RULE16: host waits 600 ns external or 7 us internal after standby wake.
// RULE17: full shutdown takes effect on the completing write strobe rise.
// RULE18: leaving full shutdown to normal powers up and tracks on that write.
// RULE19: word select high gives word mode, low gives byte mode.
// RULE20: convert start fall begins conversion; busy high until end.
// RULE21: in byte mode the mode changes only when the high byte lands.
module acpm_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host write bus
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic word_byte_select,
   input wire logic [11:0] data_in,
   // conversion control
   input wire logic convert_start_n,
   input wire logic conversion_clock_in,
   // status
   output logic busy,
   output logic [11:0] ctrl_word,
   output acpm_pkg::acpm_mode_t power_mode,
   output acpm_pkg::acpm_pwr_t pwr
);
   typedef enum logic [1:0] {
      ACPM_ST_UP = 2'h0,
      ACPM_ST_CONV = 2'h1,
      ACPM_ST_DOWN = 2'h2
   } acpm_state_t;

   acpm_pkg::acpm_wbus_t bus;
   logic [11:0] ctrl;
   logic load;
   logic high_load;
   logic cs_rise;
   logic cs_fall;
   logic ck_fall;
   acpm_pkg::acpm_mode_t mode_q;
   acpm_pkg::acpm_mode_t mode_d;
   acpm_state_t state_q;
   acpm_state_t state_d;
   logic track_q;
   logic track_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic conv_done;
   logic auto_mode;
   logic leave_full;
   logic [1:0] next_mode;
   logic enter_full;

   // bundle the host pins
   assign bus.cs_n = cs_n;
   assign bus.wr_n = wr_n;
   assign bus.word_byte_select = word_byte_select; // [RULE19]
   assign bus.data = data_in;

   // write port with word and byte assembly
   acpm_wr u_wr ( // [RULE1] [RULE2] [RULE3] [RULE6] [RULE7]
      .clk(clk),
      .sys_rst(sys_rst),
      .bus(bus),
      .ctrl(ctrl),
      .load(load),
      .high_load(high_load)
   );

   // convert start edges
   acpm_edge u_cs (
      .clk(clk),
      .sys_rst(sys_rst),
      .level(convert_start_n),
      .rise(cs_rise),
      .fall(cs_fall)
   );

   // conversion clock falls, found as rises of the inverted clock so its idle-low level gives no false edge
   acpm_edge u_ck (
      .clk(clk),
      .sys_rst(sys_rst),
      .level(~conversion_clock_in),
      .rise(ck_fall),
      .fall()
   );

   // mode follows the word only after a write that carries the upper bits; byte mode uses the stored low byte
   assign next_mode = word_byte_select ? data_in[`ACPM_PM1_POS:`ACPM_PM0_POS] : ctrl[`ACPM_PM1_POS:`ACPM_PM0_POS];
   assign mode_d = high_load ? acpm_pkg::acpm_mode_t'(next_mode) : mode_q; // [RULE21] [RULE8]
   assign enter_full = high_load & (mode_d == acpm_pkg::ACPM_FULLSHUT); // [RULE17]

   assign auto_mode = (mode_q == acpm_pkg::ACPM_AUTOSHUT) | (mode_q == acpm_pkg::ACPM_AUTOSTBY);
   assign leave_full = high_load & (mode_q == acpm_pkg::ACPM_FULLSHUT) &
                       (mode_d != acpm_pkg::ACPM_FULLSHUT);
   assign conv_done = (state_q == ACPM_ST_CONV) & ck_fall & (cnt_q == `ACPM_CONV_EDGES - 4'h1);

   // power state machine
   always_comb begin
      state_d = state_q;
      track_d = track_q;
      cnt_d = cnt_q;
      unique case (state_q)
         ACPM_ST_UP: begin
            if (enter_full) begin
               state_d = ACPM_ST_DOWN; // [RULE17]
               track_d = 1'b0;
            end else if (cs_fall && track_q) begin
               state_d = ACPM_ST_CONV; // [RULE20]
               track_d = 1'b0;
               cnt_d = 4'h0;
            end else if (cs_rise) begin
               track_d = 1'b1; // [RULE10]
            end
         end
         ACPM_ST_CONV: begin
            if (cs_rise && !conv_done) begin
               state_d = ACPM_ST_UP; // early rise aborts back to track, completion wins a tie [RULE20]
               track_d = 1'b1;
            end else if (ck_fall) begin
               cnt_d = cnt_q + 4'h1;
               if (conv_done) begin
                  state_d = auto_mode ? ACPM_ST_DOWN : ACPM_ST_UP; // [RULE11] [RULE15]
                  track_d = ~auto_mode & ~convert_start_n;
               end
            end
            if (enter_full) begin
               state_d = ACPM_ST_DOWN; // [RULE17]
               track_d = 1'b0;
            end
         end
         ACPM_ST_DOWN: begin
            if (leave_full) begin
               state_d = ACPM_ST_UP; // [RULE18]
               track_d = 1'b1;
            end else if (mode_q != acpm_pkg::ACPM_FULLSHUT && cs_rise) begin
               state_d = ACPM_ST_UP; // [RULE12] [RULE15]
               track_d = 1'b1;
            end else if (high_load && mode_d == acpm_pkg::ACPM_NORMAL) begin
               state_d = ACPM_ST_UP;
               track_d = 1'b1;
            end
            if (enter_full) begin
               state_d = ACPM_ST_DOWN; // a full shutdown write beats a wake in the same cycle [RULE17]
               track_d = 1'b0;
            end
         end
         default: begin
            state_d = ACPM_ST_UP;
            track_d = 1'b0;
         end
      endcase
   end

   // state registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_q <= acpm_pkg::ACPM_NORMAL; // [RULE9]
         state_q <= ACPM_ST_UP;
         track_q <= 1'b0; // [RULE10]
         cnt_q <= 4'h0;
      end else begin
         mode_q <= mode_d;
         state_q <= state_d;
         track_q <= track_d;
         cnt_q <= cnt_d;
      end
   end

   // status outputs
   assign busy = (state_q == ACPM_ST_CONV); // [RULE20]
   assign ctrl_word = ctrl; // word retained in every mode [RULE11]
   assign power_mode = mode_q;
   assign pwr.powered = (state_q != ACPM_ST_DOWN);
   assign pwr.ref_on = (state_q != ACPM_ST_DOWN) | (mode_q == acpm_pkg::ACPM_AUTOSTBY); // [RULE15]
   assign pwr.track = track_q;

   // assertions on the write path
   a_word_load: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
      load && word_byte_select |=> ctrl == $past(data_in))
      else $error("word not loaded");
   a_low_byte: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
      load && !word_byte_select && !data_in[`ACPM_HIGH_BYTE_ENABLE_POS] |=> ctrl == {$past(ctrl[11:8]), $past(data_in[7:0])})
      else $error("low byte misplaced");
   a_high_byte: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
      load && !word_byte_select && data_in[`ACPM_HIGH_BYTE_ENABLE_POS] |=> ctrl[11:8] == $past(data_in[3:0]))
      else $error("high byte misplaced");
   a_high_keep: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
      load && !word_byte_select && data_in[`ACPM_HIGH_BYTE_ENABLE_POS] |=> ctrl[7:0] == $past(ctrl[7:0]))
      else $error("high byte write disturbed low byte");
   a_capture_only: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
      !load |=> $stable(ctrl))
      else $error("word changed without strobe rise");
   a_gate: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
      load |-> $past(!cs_n && !wr_n))
      else $error("write without select");

   // assertions on the mode bits
   a_reset_normal: assert property (@(posedge clk) // [RULE9]
      $fell(sys_rst) |-> mode_q == acpm_pkg::ACPM_NORMAL)
      else $error("mode not normal after reset");
   a_normal_up: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
      mode_q == acpm_pkg::ACPM_NORMAL |-> pwr.powered)
      else $error("normal mode not powered");
   a_mode_code: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
      load && word_byte_select |=> mode_q == $past(data_in[`ACPM_PM1_POS:`ACPM_PM0_POS]))
      else $error("mode bits not applied");
   a_low_byte_mode: assert property (@(posedge clk) disable iff (sys_rst) // [RULE21]
      load && !high_load |=> $stable(mode_q))
      else $error("mode moved on low byte");
   a_mode_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE21]
      !high_load |=> $stable(mode_q))
      else $error("mode moved without upper write");

   // assertions on conversion and track
   a_first_track: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
      state_q == ACPM_ST_UP && !track_q && cs_rise && !enter_full |=> pwr.track)
      else $error("rise did not start track");
   a_hold_fall: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
      state_q == ACPM_ST_UP && !track_q && cs_fall |=> !busy)
      else $error("conversion started from hold");
   a_busy_start: assert property (@(posedge clk) disable iff (sys_rst) // [RULE20]
      state_q == ACPM_ST_UP && track_q && cs_fall && !high_load |=> busy)
      else $error("busy not raised on start");
   a_track_start: assert property (@(posedge clk) disable iff (sys_rst) // [RULE20]
      state_q == ACPM_ST_UP && track_q && cs_fall && !high_load |=> !pwr.track)
      else $error("no hold at conversion start");
   a_busy_stay: assert property (@(posedge clk) disable iff (sys_rst) // [RULE20]
      busy && !conv_done && !cs_rise && !enter_full |=> busy)
      else $error("busy dropped early");
   a_busy_end: assert property (@(posedge clk) disable iff (sys_rst) // [RULE20]
      busy && conv_done |=> !busy)
      else $error("busy stuck after last edge");
   a_abort: assert property (@(posedge clk) disable iff (sys_rst) // [RULE20]
      busy && cs_rise && !conv_done && !enter_full |=> !busy && pwr.track)
      else $error("early rise did not abort");
   a_conv_count: assert property (@(posedge clk) disable iff (sys_rst) // [RULE20]
      busy && ck_fall && !conv_done && !cs_rise && !enter_full |=> cnt_q == $past(cnt_q) + 4'h1)
      else $error("conversion edge not counted");
   a_cnt_range: assert property (@(posedge clk) disable iff (sys_rst) // [RULE20]
      busy |-> cnt_q < `ACPM_CONV_EDGES)
      else $error("conversion counter out of range");

   // assertions on the power states
   a_full_down: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
      enter_full |=> !pwr.powered && !pwr.track)
      else $error("full shutdown not taken at write");
   a_full_stay: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
      mode_q == acpm_pkg::ACPM_FULLSHUT && !high_load |=> !pwr.powered && !pwr.track)
      else $error("left full shutdown without write");
   a_auto_down: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
      conv_done && auto_mode && !high_load |=> !pwr.powered && !busy)
      else $error("auto mode did not power down");
   a_down_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
      !pwr.powered |-> !pwr.track && !busy)
      else $error("tracking while powered down");
   a_shut_ref: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
      !pwr.powered && mode_q != acpm_pkg::ACPM_AUTOSTBY |-> !pwr.ref_on)
      else $error("reference on in shutdown");
   a_auto_stay: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
      state_q == ACPM_ST_DOWN && auto_mode && !cs_rise && !high_load |=> !pwr.powered)
      else $error("woke without convert start rise");
   a_wake_rise: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
      state_q == ACPM_ST_DOWN && auto_mode && cs_rise && !enter_full |=> pwr.powered && pwr.track)
      else $error("no wake on convert start rise");
   a_stby_ref: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
      mode_q == acpm_pkg::ACPM_AUTOSTBY |-> pwr.ref_on)
      else $error("reference off in standby");
   a_ref_up: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
      pwr.powered |-> pwr.ref_on)
      else $error("reference off while powered");
   a_leave_full: assert property (@(posedge clk) disable iff (sys_rst) // [RULE18]
      leave_full |=> pwr.powered && pwr.track)
      else $error("no power up on leaving shutdown");
   a_leave_mode: assert property (@(posedge clk) disable iff (sys_rst) // [RULE18]
      leave_full |=> power_mode != acpm_pkg::ACPM_FULLSHUT)
      else $error("mode still full after leaving");

   // main scenarios reached
   c_conv: cover property (@(posedge clk) disable iff (sys_rst) conv_done);
   c_auto_wake: cover property (@(posedge clk) disable iff (sys_rst)
      state_q == ACPM_ST_DOWN && cs_rise);
   c_full: cover property (@(posedge clk) disable iff (sys_rst) leave_full);
   c_abort: cover property (@(posedge clk) disable iff (sys_rst) busy && cs_rise && !conv_done);
   c_byte_high: cover property (@(posedge clk) disable iff (sys_rst) high_load && !word_byte_select);
endmodule
`default_nettype wire

// file: hdl/acpm_edge.sv
`timescale 1ns/10ps
`default_nettype none
// registered edge finder on a synchronous level
module acpm_edge (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // level in
   input wire logic level,
   // edges out
   output logic rise,
   output logic fall
);
   logic level_q;
   // previous level, reset high so idle-high lines give no false edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         level_q <= 1'b1;
      end else begin
         level_q <= level;
      end
   end
   assign rise = level & ~level_q;
   assign fall = ~level & level_q;
endmodule
`default_nettype wire

// file: hdl/acpm_pkg.sv
package acpm_pkg;
   typedef enum logic [1:0] {
      ACPM_NORMAL = 2'h0,
      ACPM_AUTOSHUT = 2'h1,
      ACPM_AUTOSTBY = 2'h2,
      ACPM_FULLSHUT = 2'h3
   } acpm_mode_t;
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic word_byte_select;
      logic [11:0] data;
   } acpm_wbus_t;
   typedef struct packed {
      logic powered;
      logic ref_on;
      logic track;
   } acpm_pwr_t;
endpackage

// file: hdl/acpm_regs.svh
`ifndef ACPM_REGS_SVH
`define ACPM_REGS_SVH
// control word layout
`define ACPM_CTRL_W 12
`define ACPM_PM1_POS 1
`define ACPM_PM0_POS 0
`define ACPM_CTRL_RST 12'h000
// pin positions
`define ACPM_HIGH_BYTE_ENABLE_POS 8
// power mode codes
`define ACPM_PM_NORMAL 2'h0
`define ACPM_PM_AUTOSHUT 2'h1
`define ACPM_PM_AUTOSTBY 2'h2
`define ACPM_PM_FULLSHUT 2'h3
// conversion length in conversion clock falling edges
`define ACPM_CONV_EDGES 4'he
`endif

// file: hdl/acpm_wr.sv
`timescale 1ns/10ps
`include "acpm_regs.svh"
`default_nettype none
// write port: gates select with strobe and assembles the control word
module acpm_wr (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host bus
   input wire acpm_pkg::acpm_wbus_t bus,
   // loaded word
   output logic [11:0] ctrl,
   output logic load,
   output logic high_load
);
   logic gate_n;
   logic wr_rise;
   logic high_byte_enable;
   logic [11:0] ctrl_q;
   logic [11:0] ctrl_d;
   // write active only while both select and strobe low
   assign gate_n = bus.cs_n | bus.wr_n; // [RULE7]
   acpm_edge u_edge (
      .clk(clk),
      .sys_rst(sys_rst),
      .level(gate_n),
      .rise(wr_rise),
      .fall()
   );
   assign high_byte_enable = bus.data[`ACPM_HIGH_BYTE_ENABLE_POS];
   // word mode takes all, byte mode one half
   assign ctrl_d = bus.word_byte_select ? bus.data : // [RULE1]
                   high_byte_enable ? {bus.data[3:0], ctrl_q[7:0]} : // [RULE3]
                   {ctrl_q[11:8], bus.data[7:0]}; // [RULE2]
   assign load = wr_rise;
   assign high_load = wr_rise & (bus.word_byte_select | high_byte_enable);
   // capture on the strobe rising edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= `ACPM_CTRL_RST;
      end else if (wr_rise) begin
         ctrl_q <= ctrl_d; // [RULE6]
      end
   end
   assign ctrl = ctrl_q;
endmodule
`default_nettype wire

// file: tb/acpm_host.sv
`timescale 1ns/10ps
`default_nettype none
// host side: write strobes, convert start and a conversion clock that runs only in conversions
module acpm_host (
   // clock
   input wire logic clk,
   // host bus and conversion pins
   output var acpm_pkg::acpm_wbus_t bus,
   output logic convert_start_n,
   output logic conversion_clock_in
);
   // idle levels: strobes high, convert start high, clock still
   initial begin
      bus = '{cs_n: 1'b1, wr_n: 1'b1, word_byte_select: 1'b1, data: 12'h000};
      convert_start_n = 1'b1;
      conversion_clock_in = 1'b0;
   end

   // one write cycle; sel low makes a strobe without chip select
   task automatic write(input logic wbs, input logic [11:0] d, input logic sel);
      @(posedge clk);
      #1;
      bus.word_byte_select = wbs;
      bus.data = d;
      bus.cs_n = ~sel;
      bus.wr_n = 1'b0;
      @(posedge clk);
      #1;
      bus.wr_n = 1'b1; // capture edge
      bus.cs_n = 1'b1;
      @(posedge clk);
      #1;
      bus.data = ~d; // released lines must not keep the last value
   endtask

   // convert start falls and then idles low
   task automatic start_conv();
      @(posedge clk);
      #1;
      convert_start_n = 1'b0;
   endtask

   // convert start rises, then the power-up wait passes
   task automatic wake(input int wait_cyc);
      @(posedge clk);
      #1;
      convert_start_n = 1'b1;
      repeat (wait_cyc) @(posedge clk);
   endtask

   // n falling edges of the conversion clock, slower than clk/2
   task automatic clock_falls(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         conversion_clock_in = 1'b1;
         repeat (3) @(posedge clk);
         #1;
         conversion_clock_in = 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/tb_acpm_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_acpm_ctrl;
   localparam int WAKE_CYC = 20; // shortened power-up wait
   logic clk;
   logic sys_rst;
   acpm_pkg::acpm_wbus_t bus;
   logic convert_start_n;
   logic conversion_clock_in;
   logic busy;
   logic [11:0] ctrl_word;
   acpm_pkg::acpm_mode_t power_mode;
   acpm_pkg::acpm_pwr_t pwr;
   logic cs_n;
   logic wr_n;
   logic word_byte_select;
   logic [11:0] data_in;
   int failures;
   int comparisons;

   // block and its host
   assign cs_n = bus.cs_n;
   assign wr_n = bus.wr_n;
   assign word_byte_select = bus.word_byte_select;
   assign data_in = bus.data;
   acpm_ctrl u_acpm_ctrl (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .wr_n(wr_n),
      .word_byte_select(word_byte_select), .data_in(data_in), .convert_start_n(convert_start_n),
      .conversion_clock_in(conversion_clock_in), .busy(busy), .ctrl_word(ctrl_word),
      .power_mode(power_mode), .pwr(pwr));
   acpm_host u_acpm_host (.clk(clk), .bus(bus), .convert_start_n(convert_start_n),
      .conversion_clock_in(conversion_clock_in));

   // verdict and end of run
   task automatic end_sim();
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input bit ok, input string msg);
      comparisons++;
      if (!ok) begin
         failures++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   // wait n edges, sample after the updates land
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // reset state, hold until the first convert start rise
   task automatic t_reset();
      chk(ctrl_word === 12'h000 && power_mode === acpm_pkg::ACPM_NORMAL, "reset word");
      chk(pwr === 3'b110 && busy === 1'b0, "reset power");
      u_acpm_host.start_conv();
      cyc(3);
      chk(busy === 1'b0, "conversion in hold");
      u_acpm_host.wake(0);
      cyc(3);
      chk(pwr.track === 1'b1, "first rise tracks");
   endtask

   // normal conversion length, then an aborted one
   task automatic t_conv();
      u_acpm_host.start_conv();
      cyc(3);
      chk(busy === 1'b1 && pwr.track === 1'b0, "busy start");
      u_acpm_host.clock_falls(13);
      cyc(0);
      chk(busy === 1'b1, "busy early end");
      u_acpm_host.clock_falls(1);
      cyc(2);
      chk(busy === 1'b0 && pwr.powered === 1'b1, "normal end");
      u_acpm_host.wake(0);
      u_acpm_host.start_conv();
      u_acpm_host.clock_falls(5);
      u_acpm_host.wake(0);
      cyc(3);
      chk(busy === 1'b0 && pwr.track === 1'b1, "abort");
   endtask

   // every mode by word write, full shutdown and its exit, refused strobe
   task automatic t_word();
      logic [11:0] d;
      for (int i = 0; i < 4; i++) begin
         d = 12'ha5c + 12'(i);
         u_acpm_host.write(1'b1, d, 1'b1);
         cyc(2);
         chk(ctrl_word === d, "word load");
         chk(power_mode === acpm_pkg::acpm_mode_t'(i[1:0]), "mode code");
      end
      chk(pwr === 3'b000, "full shutdown");
      u_acpm_host.start_conv();
      cyc(3);
      chk(busy === 1'b0, "no conversion in shutdown");
      u_acpm_host.wake(0);
      cyc(3);
      chk(pwr.powered === 1'b0 && ctrl_word === 12'ha5f, "stays shut");
      u_acpm_host.write(1'b1, 12'h000, 1'b1);
      cyc(2);
      chk(pwr.powered === 1'b1 && pwr.track === 1'b1, "leave shutdown");
      u_acpm_host.write(1'b1, 12'hfff, 1'b0);
      cyc(2);
      chk(ctrl_word === 12'h000, "write without select");
   endtask

   // byte mode: low byte first, mode applies with the high byte
   task automatic t_byte();
      u_acpm_host.write(1'b0, 12'h0a6, 1'b1);
      cyc(2);
      chk(ctrl_word[7:0] === 8'ha6, "low byte");
      chk(power_mode === acpm_pkg::ACPM_NORMAL, "mode waits");
      u_acpm_host.write(1'b0, 12'h105, 1'b1);
      cyc(2);
      chk(ctrl_word === 12'h5a6, "high byte");
      chk(power_mode === acpm_pkg::ACPM_AUTOSTBY, "mode applied");
   endtask

   // one conversion in an automatic mode, power down at end, wake on rise
   task automatic t_auto(input acpm_pkg::acpm_pwr_t down, input logic [11:0] w);
      u_acpm_host.start_conv();
      u_acpm_host.clock_falls(14);
      cyc(3);
      chk(busy === 1'b0 && pwr === down && ctrl_word === w, "auto down");
      u_acpm_host.wake(WAKE_CYC);
      cyc(1);
      chk(pwr.powered === 1'b1 && pwr.track === 1'b1, "auto wake");
   endtask

   // reset in mid-run returns to normal mode with the sampler in hold
   task automatic t_rerun();
      @(posedge clk);
      #1;
      sys_rst = 1'b1;
      cyc(3);
      @(posedge clk);
      #1;
      sys_rst = 1'b0;
      cyc(2);
      chk(ctrl_word === 12'h000 && power_mode === acpm_pkg::ACPM_NORMAL, "rerun word");
      chk(pwr === 3'b110 && busy === 1'b0, "rerun power");
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // main sequence
   initial begin
      failures = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      cyc(2);
      t_reset();
      t_conv();
      t_word();
      t_byte();
      t_auto(3'b010, 12'h5a6);
      u_acpm_host.write(1'b1, 12'h001, 1'b1);
      u_acpm_host.wake(0);
      t_auto(3'b000, 12'h001);
      t_rerun();
      end_sim();
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_sim();
   end
endmodule
`default_nettype wire
